// ==== sct_pkg.sv ====
// sct_pkg: constants and types shared by the capture/compare timer.
// assumes a single system clock; the cpu side uses a simple select port.
`default_nettype none

package sct_pkg;

  // ==========================================================
  // widths
  // ==========================================================
  localparam int unsigned CNT_W   = 16;            // count and capture widths
  localparam int unsigned PWM_W   = 14;            // pwm duty resolution
  localparam int unsigned PWM_LSB = 2;             // duty sits above two zero bits
  localparam int unsigned SEL_W   = 2;             // register select width

  // ==========================================================
  // reset and limit values
  // ==========================================================
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;  // count after reset
  localparam logic [CNT_W-1:0] COUNT_MAX   = 16'hFFFF;  // value before wrap
  localparam logic [CNT_W-1:0] COUNT_ONE   = 16'h0001;  // count step

  // ==========================================================
  // register selects on the cpu port
  // ==========================================================
  localparam logic [SEL_W-1:0] SEL_CC_ZERO = 2'h0;  // capture_compare_zero
  localparam logic [SEL_W-1:0] SEL_CC_ONE  = 2'h1;  // capture_compare_one
  localparam logic [SEL_W-1:0] SEL_COUNT   = 2'h2;  // timer_count_value

  // ==========================================================
  // three-bit operating mode field codes
  // ==========================================================
  localparam logic [2:0] MODE_STOP      = 3'h0;  // stopped, count held at zero
  localparam logic [2:0] MODE_PWM       = 3'h1;  // free running pwm
  localparam logic [2:0] MODE_FREE      = 3'h2;  // free running
  localparam logic [2:0] MODE_FREE_EDGE = 3'h3;  // free running, output on edge too
  localparam logic [2:0] MODE_EDGE_CLR  = 3'h4;  // clear on input a valid edge
  localparam logic [2:0] MODE_EDGE_CLR2 = 3'h5;  // same, output on edge too
  localparam logic [2:0] MODE_MATCH_CLR = 3'h6;  // clear on zero-register match
  localparam logic [2:0] MODE_MATCH_CL2 = 3'h7;  // same, output on edge too

  // ==========================================================
  // edge code values (high bit, low bit)
  // ==========================================================
  localparam logic [1:0] EDGE_FALL = 2'h0;  // valid edge falling
  localparam logic [1:0] EDGE_RISE = 2'h1;  // valid edge rising
  localparam logic [1:0] EDGE_BAD  = 2'h2;  // prohibited, treated as none
  localparam logic [1:0] EDGE_BOTH = 2'h3;  // both edges valid

  // ==========================================================
  // control bits that software sets outside this block
  // ==========================================================
  typedef struct packed {
    logic [2:0] mode;              // mode_control_reg operating mode
    logic       role_select_zero;  // 1: zero register captures
    logic       role_select_one;   // 1: one register captures
    logic       cap0_from_b;       // 1: zero register captures on input b
    logic [1:0] edge_code_a;       // edge_code_high, edge_code_low for input a
    logic [1:0] edge_code_b;       // edge code for input b
    logic       count_from_a;      // 1: count on input a valid edge
    logic       one_shot;          // 1: output set on one-match, clear on zero
  } sct_ctrl_t;

endpackage

`default_nettype wire

// ==== sct_timer.sv ====
// sct_timer: 16-bit count with two capture/compare registers and one output.
// assumes timer inputs and the count tick are synchronous to i_clk_sys.
//
// Functional notes
// R1: count is 16 bits, steps per count pulse
// R2: reset loads count with zero
// R3: capture/compare registers undefined after reset
// R4: role_select_zero picks capture or compare role
// R5: role_select_one picks capture or compare role
// R6: zero register equality raises match zero request
// R7: one register equality raises match one request
// R8: zero register holds interval or pwm width
// R9: zero register captures on input a or b
// R10: input a capture edge is opposite valid edge
// R11: one register captures on input a edge
// R12: capture skipped during read, flag still set
// R13: software sets one register to capture first
// R14: count read goes through one register
// R15: pwm output has 14-bit resolution
// R16: software puts pwm duty in upper bits
// R17: software never loads zero register with zero
// R18: lowered compare lets count overflow and wrap
// R19: pulse width measured by edge captures
// R20: event counting steps on input pulses
// R21: one-shot pulse output of free width
// R22: stop mode holds zero, output, no matches
// R23: overflow sets readable overflow flag
// R24: count wraps from all ones to zero
`timescale 1ns/1ps
`default_nettype none

module sct_timer
  import sct_pkg::*;
(
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  // cpu register port
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  input  wire logic [SEL_W-1:0] i_reg_sel,
  input  wire logic [CNT_W-1:0] i_reg_wdata,
  output logic      [CNT_W-1:0] o_reg_rdata,
  // control bits and internal count clock
  input  wire sct_ctrl_t        i_ctrl,
  input  wire logic             i_count_tick,
  input  wire logic             i_ovf_clear,
  // timer pins
  input  wire logic             i_timer_input_a,
  input  wire logic             i_timer_input_b,
  output logic                  o_timer_out_pin,
  // requests and status
  output logic                  o_match_zero_irq,
  output logic                  o_match_one_irq,
  output logic                  o_input_irq_flag,
  output logic                  o_overflow_flag
);

  // ==========================================================
  // state
  // ==========================================================
  logic [CNT_W-1:0] count_reg;      // running count
  logic [CNT_W-1:0] count_next;     // next count value
  logic [CNT_W-1:0] cc_zero_reg;    // capture_compare_zero
  logic [CNT_W-1:0] cc_one_reg;     // capture_compare_one
  logic             in_a_reg;       // input a last cycle
  logic             in_b_reg;       // input b last cycle
  logic             match0_reg;     // zero equality last cycle
  logic             match1_reg;     // one equality last cycle

  // ==========================================================
  // edge detection
  // ==========================================================
  logic rise_a;        // input a rose
  logic fall_a;        // input a fell
  logic rise_b;        // input b rose
  logic fall_b;        // input b fell
  logic valid_a;       // input a valid edge
  logic valid_b;       // input b valid edge
  logic cap_edge_a;    // opposite edge for zero register capture

  assign rise_a = i_timer_input_a & ~in_a_reg;
  assign fall_a = ~i_timer_input_a & in_a_reg;
  assign rise_b = i_timer_input_b & ~in_b_reg;
  assign fall_b = ~i_timer_input_b & in_b_reg;

  // valid edge per edge code, prohibited code gives none
  always_comb begin
    case (i_ctrl.edge_code_a)
      EDGE_FALL: valid_a = fall_a;
      EDGE_RISE: valid_a = rise_a;
      EDGE_BOTH: valid_a = rise_a | fall_a;
      default:   valid_a = 1'b0;
    endcase
  end

  always_comb begin
    case (i_ctrl.edge_code_b)
      EDGE_FALL: valid_b = fall_b;
      EDGE_RISE: valid_b = rise_b;
      EDGE_BOTH: valid_b = rise_b | fall_b;
      default:   valid_b = 1'b0;
    endcase
  end

  // zero register capture edge is the reverse of the valid edge
  always_comb begin
    case (i_ctrl.edge_code_a)
      EDGE_FALL: cap_edge_a = rise_a;  // see R10
      EDGE_RISE: cap_edge_a = fall_a;  // see R10
      default:   cap_edge_a = 1'b0;    // both edges or prohibited: none
    endcase
  end

  // pin history for edge detection
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      in_a_reg <= 1'b0;
      in_b_reg <= 1'b0;
    end else begin
      in_a_reg <= i_timer_input_a;
      in_b_reg <= i_timer_input_b;
    end
  end

  // ==========================================================
  // count
  // ==========================================================
  logic running;     // mode other than stop
  logic tick;        // one count pulse this cycle
  logic edge_clr;    // clear on input a valid edge
  logic match_clr;   // clear on zero-register match
  logic wrap;        // count leaves all ones

  assign running   = (i_ctrl.mode != MODE_STOP);
  // external event counting uses input a valid edges
  assign tick      = running & (i_ctrl.count_from_a ? valid_a : i_count_tick);  // see R20
  assign edge_clr  = valid_a &
                     ((i_ctrl.mode == MODE_EDGE_CLR) | (i_ctrl.mode == MODE_EDGE_CLR2));
  assign match_clr = tick & (count_reg == cc_zero_reg) &
                     ((i_ctrl.mode == MODE_MATCH_CLR) | (i_ctrl.mode == MODE_MATCH_CL2));
  assign wrap      = tick & (count_reg == COUNT_MAX) & ~match_clr & ~edge_clr;

  // next count: stop holds zero, clears win over stepping
  always_comb begin
    if (!running) begin
      count_next = COUNT_RESET;                   // see R22
    end else if (edge_clr || match_clr) begin
      count_next = COUNT_RESET;                   // see R8
    end else if (tick) begin
      count_next = count_reg + COUNT_ONE;         // see R1, R24, R18
    end else begin
      count_next = count_reg;
    end
  end

  // count register
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      count_reg <= COUNT_RESET;                   // see R2
    end else begin
      count_reg <= count_next;
    end
  end

  // overflow flag: set wins over clear
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_overflow_flag <= 1'b0;
    end else if (wrap) begin
      o_overflow_flag <= 1'b1;                    // see R23
    end else if (i_ovf_clear) begin
      o_overflow_flag <= 1'b0;
    end
  end

  // ==========================================================
  // capture/compare registers (no reset: undefined at start)
  // ==========================================================
  logic cap0;        // zero register capture this cycle
  logic cap1;        // one register capture this cycle
  logic rd_one;      // cpu reads the one register
  logic rd_count;    // cpu reads the count

  assign rd_one   = i_reg_rd & (i_reg_sel == SEL_CC_ONE);
  assign rd_count = i_reg_rd & (i_reg_sel == SEL_COUNT);
  // zero register trigger from input a opposite edge or input b
  assign cap0 = i_ctrl.role_select_zero &
                (i_ctrl.cap0_from_b ? valid_b : cap_edge_a);           // see R4, R9, R19
  // one register takes input a valid edge unless being read
  assign cap1 = i_ctrl.role_select_one & valid_a & ~rd_one;          // see R5, R11, R12

  // zero register: cpu write wins over capture
  always_ff @(posedge i_clk_sys) begin                             // see R3
    if (i_reg_wr && (i_reg_sel == SEL_CC_ZERO)) begin
      cc_zero_reg <= i_reg_wdata;
    end else if (cap0) begin
      cc_zero_reg <= count_reg;
    end
  end

  // one register: count read copy, then write, then capture
  always_ff @(posedge i_clk_sys) begin                             // see R3
    if (rd_count) begin
      cc_one_reg <= count_reg;                    // see R14
    end else if (i_reg_wr && (i_reg_sel == SEL_CC_ONE)) begin
      cc_one_reg <= i_reg_wdata;
    end else if (cap1) begin
      cc_one_reg <= count_reg;
    end
  end

  // read data, registered one cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= COUNT_RESET;
    end else if (i_reg_rd) begin
      if (i_reg_sel == SEL_CC_ZERO) begin
        o_reg_rdata <= cc_zero_reg;
      end else if (i_reg_sel == SEL_CC_ONE) begin
        o_reg_rdata <= cc_one_reg;
      end else if (i_reg_sel == SEL_COUNT) begin
        o_reg_rdata <= count_reg;                 // see R14
      end else begin
        o_reg_rdata <= COUNT_RESET;               // unmapped select
      end
    end
  end

  // input request flag pulses on every input a valid edge
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_input_irq_flag <= 1'b0;
    end else begin
      o_input_irq_flag <= valid_a;                // see R12
    end
  end

  // ==========================================================
  // compare matches
  // ==========================================================
  logic eq0;         // zero register equals count
  logic eq1;         // one register equals count
  logic hit0;        // new zero-register match
  logic hit1;        // new one-register match

  assign eq0  = (count_reg == cc_zero_reg);
  assign eq1  = (count_reg == cc_one_reg);
  assign hit0 = running & ~i_ctrl.role_select_zero & eq0 & ~match0_reg;  // see R6
  assign hit1 = running & ~i_ctrl.role_select_one & eq1 & ~match1_reg;   // see R7

  // equality history so a match pulses once
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      match0_reg <= 1'b0;
      match1_reg <= 1'b0;
    end else begin
      match0_reg <= eq0;
      match1_reg <= eq1;
    end
  end

  // match requests, one-cycle pulses, silent when stopped
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_match_zero_irq <= 1'b0;
      o_match_one_irq  <= 1'b0;
    end else begin
      o_match_zero_irq <= hit0;                   // see R6, R22
      o_match_one_irq  <= hit1;                   // see R7, R22
    end
  end

  // ==========================================================
  // timer output
  // ==========================================================
  logic edge_out;    // modes that also toggle on input a edge
  logic pwm_level;   // pwm comparison result

  assign edge_out  = (i_ctrl.mode == MODE_FREE_EDGE) | (i_ctrl.mode == MODE_EDGE_CLR2) |
                     (i_ctrl.mode == MODE_MATCH_CL2);
  // 14-bit duty taken from the upper bits of the zero register
  assign pwm_level = (count_reg[PWM_W-1:0] < cc_zero_reg[CNT_W-1:PWM_LSB]);  // see R15

  // output pin: held in stop, pwm level, one-shot or toggle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_timer_out_pin <= 1'b0;
    end else if (!running) begin
      o_timer_out_pin <= o_timer_out_pin;         // see R22
    end else if (i_ctrl.mode == MODE_PWM) begin
      o_timer_out_pin <= pwm_level;               // see R15
    end else if (i_ctrl.one_shot) begin
      if (hit1) begin
        o_timer_out_pin <= 1'b1;                  // see R21
      end else if (hit0) begin
        o_timer_out_pin <= 1'b0;                  // see R21
      end
    end else if (hit0 || hit1 || (edge_out && valid_a)) begin
      o_timer_out_pin <= ~o_timer_out_pin;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  count_stop_a: assert property (  // see R22
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_ctrl.mode == MODE_STOP) |=> (count_reg == COUNT_RESET))
    else $error("count not held at zero while stopped");

  stop_quiet_a: assert property (  // see R22
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_ctrl.mode == MODE_STOP) [*2] |=>
      (!o_match_zero_irq && !o_match_one_irq && $stable(o_timer_out_pin)))
    else $error("activity while stopped");

  count_step_a: assert property (  // see R1
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (tick && !edge_clr && !match_clr && count_reg != COUNT_MAX) |=>
      (count_reg == $past(count_reg) + COUNT_ONE))
    else $error("count did not step by one");

  count_wrap_a: assert property (  // see R24, R23
    @(posedge i_clk_sys) disable iff (!i_nrst)
    wrap |=> (count_reg == COUNT_RESET) && o_overflow_flag)
    else $error("wrap did not clear count and flag overflow");

  ovf_hold_a: assert property (  // see R23
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (o_overflow_flag && !i_ovf_clear) |=> o_overflow_flag)
    else $error("overflow flag dropped without clear");

  count_read_a: assert property (  // see R14
    @(posedge i_clk_sys) disable iff (!i_nrst)
    rd_count |=> (cc_one_reg == $past(count_reg)) && (o_reg_rdata == $past(count_reg)))
    else $error("count read not delivered through one register");

  cap_skip_a: assert property (  // see R12
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (rd_one && !i_reg_wr && valid_a) |=> ($stable(cc_one_reg) && o_input_irq_flag))
    else $error("capture during read not skipped or flag lost");

  cap_zero_a: assert property (  // see R10
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_ctrl.role_select_zero && !i_ctrl.cap0_from_b && i_ctrl.edge_code_a == EDGE_FALL &&
     rise_a && !i_reg_wr) |=> (cc_zero_reg == $past(count_reg)))
    else $error("zero register missed opposite-edge capture");

  match_zero_a: assert property (  // see R6
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (running && !i_ctrl.role_select_zero && eq0 && !match0_reg) |=> o_match_zero_irq)
    else $error("zero match request missing");

  match_one_a: assert property (  // see R7
    @(posedge i_clk_sys) disable iff (!i_nrst)
    o_match_one_irq |-> $past(eq1) && !$past(i_ctrl.role_select_one))
    else $error("one match request without equality");

endmodule

`default_nettype wire

// ==== sct_pin_src.sv ====
// sct_pin_src: far-side model driving the timer input pins.
// assumes level requests change at falling edges of i_clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sct_pin_src (
  // clock and reset
  input  wire logic   i_clk_sys,
  input  wire logic   i_nrst,
  // requested pin levels and timer output
  input  wire logic   i_want_a,
  input  wire logic   i_want_b,
  input  wire logic   i_out_pin,
  // pins and output watch
  output logic        o_pin_a,
  output logic        o_pin_b,
  output logic [15:0] o_high_cycles
);
  // ====================
  // pulse sources
  // ====================
  // pins move on a falling edge, half a cycle clear of sampling
  always_ff @(negedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_a <= 1'h0;
      o_pin_b <= 1'h0;
    end else begin
      o_pin_a <= i_want_a;
      o_pin_b <= i_want_b;
    end
  end

  // ====================
  // output watch
  // ====================
  // counts the cycles the timer output sits high
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_high_cycles <= 16'h0000;
    end else if (i_out_pin === 1'h1) begin
      o_high_cycles <= o_high_cycles + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// ==== sixteen_bit_capture_compare_timer_tb.sv ====
// sixteen_bit_capture_compare_timer_tb: self-checking bench for sct_timer.
// assumes sct_pkg is compiled first; sct_pin_src drives the timer pins.
`timescale 1ns/1ps
`default_nettype none

module sixteen_bit_capture_compare_timer_tb;
  import sct_pkg::*;

  // ====================
  // signals
  // ====================
  logic             i_clk_sys;        // system clock
  logic             i_nrst;           // reset, active low
  logic             reg_wr;           // write strobe
  logic             reg_rd;           // read strobe
  logic [SEL_W-1:0] reg_sel;          // register select
  logic [CNT_W-1:0] reg_wdata;        // write data
  logic [CNT_W-1:0] reg_rdata;        // read data
  sct_ctrl_t        ctrl;             // control bits
  logic             tick;             // count pulse
  logic             ovf_clear;        // overflow clear
  logic             want_a;           // requested input a level
  logic             want_b;           // requested input b level
  logic             pin_a;            // input a
  logic             pin_b;            // input b
  logic             out_pin;          // timer output
  logic             m0;               // match zero request
  logic             m1;               // match one request
  logic             flag;             // input request flag
  logic             ovf;              // overflow flag
  logic [15:0]      high_cycles;      // cycles output high
  int               n_errors;         // mismatches
  int               samples_checked;  // comparisons
  int               n_flag;           // input flag pulses seen

  // ====================
  // design and far side
  // ====================
  sct_timer DUT (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_sel(reg_sel), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_ctrl(ctrl), .i_count_tick(tick), .i_ovf_clear(ovf_clear),
    .i_timer_input_a(pin_a), .i_timer_input_b(pin_b), .o_timer_out_pin(out_pin),
    .o_match_zero_irq(m0), .o_match_one_irq(m1), .o_input_irq_flag(flag),
    .o_overflow_flag(ovf)
  );
  sct_pin_src u_pins (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_want_a(want_a), .i_want_b(want_b),
    .i_out_pin(out_pin), .o_pin_a(pin_a), .o_pin_b(pin_b), .o_high_cycles(high_cycles)
  );

  // 200 MHz clock
  always #2.5 i_clk_sys = ~i_clk_sys;

  // ====================
  // helpers
  // ====================
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // reset for four cycles, control back to stop
  task automatic do_reset;
    i_nrst = 1'h0;
    ctrl = '0;
    tick = 1'h0;
    want_a <= 1'h0;
    want_b <= 1'h0;
    repeat (4) @(negedge i_clk_sys);
    i_nrst = 1'h1;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [SEL_W-1:0] sel, input logic [CNT_W-1:0] dat);
    @(negedge i_clk_sys);
    reg_wr = 1'h1;
    reg_sel = sel;
    reg_wdata = dat;
    @(negedge i_clk_sys);
    reg_wr = 1'h0;
  endtask
  // one-cycle read strobe, data the cycle after
  task automatic rd(input logic [SEL_W-1:0] sel, output logic [CNT_W-1:0] dat);
    @(negedge i_clk_sys);
    reg_rd = 1'h1;
    reg_sel = sel;
    @(negedge i_clk_sys);
    reg_rd = 1'h0;
    dat = reg_rdata;
  endtask
  // n count pulses back to back
  task automatic ticks(input int n);
    @(negedge i_clk_sys);
    tick = 1'h1;
    repeat (n) @(negedge i_clk_sys);
    tick = 1'h0;
  endtask
  // move one pin, watching the input flag meanwhile
  task automatic pin(input logic on_b, input logic lvl);
    if (on_b === 1'h1) want_b <= lvl;
    else want_a <= lvl;
    repeat (3) begin
      @(negedge i_clk_sys);
      if (flag === 1'h1) n_flag++;
    end
  endtask
  // pulses of a request (0 zero, 1 one) over a fixed window
  task automatic pulses(input int idx, input int n, output logic [15:0] cnt);
    logic [1:0] v;
    cnt = 16'h0000;
    repeat (n) begin
      @(negedge i_clk_sys);
      v = {m1, m0};
      if (v[idx] === 1'h1) cnt = cnt + 16'h0001;
    end
  endtask

  // ====================
  // scenarios
  // ====================
  // reset values, count read through register one, unmapped and read-only
  task automatic t_reset;
    logic [15:0] d;
    do_reset();
    ctrl.role_select_one = 1'h1;
    chk({15'h0000, ovf}, 16'h0000);
    rd(SEL_COUNT, d);
    chk(d, COUNT_RESET);
    wr(SEL_CC_ONE, 16'hA5A5);
    rd(SEL_CC_ONE, d);
    chk(d, 16'hA5A5);
    rd(SEL_COUNT, d);
    rd(SEL_CC_ONE, d);
    chk(d, 16'h0000);
    wr(SEL_COUNT, 16'h1234);
    rd(2'h3, d);
    chk(d, 16'h0000);
    rd(SEL_COUNT, d);
    chk(d, 16'h0000);
  endtask
  // compare matches on both registers, one pulse each
  task automatic t_match;
    logic [15:0] c;
    logic [15:0] d;
    do_reset();
    wr(SEL_CC_ZERO, 16'h0003);
    wr(SEL_CC_ONE, 16'h0005);
    ctrl.mode = MODE_FREE;
    ticks(3);
    pulses(0, 4, c);
    chk(c, 16'h0001);
    ticks(2);
    pulses(1, 4, c);
    chk(c, 16'h0001);
    ctrl.role_select_one = 1'h1;
    rd(SEL_COUNT, d);
    chk(d, 16'h0005);
  endtask
  // stop mid-run: count zero, no match, output frozen
  task automatic t_stop;
    logic [15:0] c;
    logic [15:0] d;
    do_reset();
    wr(SEL_CC_ZERO, 16'h0002);
    wr(SEL_CC_ONE, 16'h7000);
    ctrl.mode = MODE_FREE;
    ticks(3);
    ctrl.mode = MODE_STOP;
    ctrl.role_select_one = 1'h1;
    ticks(4);
    pulses(0, 3, c);
    chk(c, 16'h0000);
    chk({15'h0000, out_pin}, 16'h0001);
    rd(SEL_COUNT, d);
    chk(d, 16'h0000);
  endtask
  // compare lowered below count: runs on to wrap and overflow
  task automatic t_wrap;
    logic [15:0] d;
    do_reset();
    wr(SEL_CC_ZERO, 16'h0100);
    ctrl.role_select_one = 1'h1;
    ctrl.mode = MODE_MATCH_CLR;
    ticks(16);
    wr(SEL_CC_ZERO, 16'h0004);
    ticks(65519);
    chk({15'h0000, ovf}, 16'h0000);
    rd(SEL_COUNT, d);
    chk(d, COUNT_MAX);
    ticks(1);
    rd(SEL_COUNT, d);
    chk(d, 16'h0000);
    chk({15'h0000, ovf}, 16'h0001);
    ovf_clear = 1'h1;
    @(negedge i_clk_sys);
    ovf_clear = 1'h0;
    chk({15'h0000, ovf}, 16'h0000);
  endtask
  // register zero captures on opposite edge of a, none on both, then on b
  task automatic t_cap_zero;
    logic [15:0] d;
    do_reset();
    wr(SEL_CC_ZERO, 16'h1111);
    ctrl.mode = MODE_FREE;
    ctrl.role_select_zero = 1'h1;
    ctrl.edge_code_a = EDGE_FALL;
    ticks(7);
    pin(0, 1);
    ticks(2);
    pin(0, 0);
    rd(SEL_CC_ZERO, d);
    chk(d, 16'h0007);
    ctrl.edge_code_a = EDGE_RISE;
    pin(0, 1);
    ticks(1);
    pin(0, 0);
    ctrl.edge_code_a = EDGE_BOTH;
    ticks(1);
    pin(0, 1);
    rd(SEL_CC_ZERO, d);
    chk(d, 16'h000A);
    ctrl.cap0_from_b = 1'h1;
    ctrl.edge_code_b = EDGE_RISE;
    pin(1, 1);
    rd(SEL_CC_ZERO, d);
    chk(d, 16'h000B);
  endtask
  // register one captures on a, skipped while being read
  task automatic t_cap_one;
    logic [15:0] d;
    do_reset();
    ctrl.mode = MODE_FREE;
    ctrl.role_select_one = 1'h1;
    ctrl.edge_code_a = EDGE_RISE;
    ticks(4);
    n_flag = 0;
    pin(0, 1);
    chk(16'(n_flag), 16'h0001);
    rd(SEL_CC_ONE, d);
    chk(d, 16'h0004);
    ticks(2);
    pin(0, 0);
    n_flag = 0;
    want_a <= 1'h1;
    @(negedge i_clk_sys);
    reg_rd = 1'h1;
    reg_sel = SEL_CC_ONE;
    repeat (3) begin
      @(negedge i_clk_sys);
      reg_rd = 1'h0;
      if (flag === 1'h1) n_flag++;
    end
    chk(16'(n_flag), 16'h0001);
    rd(SEL_CC_ONE, d);
    chk(d, 16'h0004);
  endtask
  // event counting on input a, internal ticks ignored
  task automatic t_event;
    logic [15:0] d;
    do_reset();
    ctrl.mode = MODE_FREE;
    ctrl.count_from_a = 1'h1;
    ctrl.edge_code_a = EDGE_RISE;
    ctrl.role_select_one = 1'h1;
    ticks(3);
    repeat (5) begin
      pin(0, 1);
      pin(0, 0);
    end
    rd(SEL_COUNT, d);
    chk(d, 16'h0005);
  endtask
  // clear on input a edge, then on zero-register match
  task automatic t_clear;
    logic [15:0] d;
    do_reset();
    wr(SEL_CC_ZERO, 16'h0009);
    ctrl.role_select_one = 1'h1;
    ctrl.edge_code_a = EDGE_RISE;
    ctrl.mode = MODE_EDGE_CLR2;
    ticks(5);
    pin(0, 1);
    ctrl.mode = MODE_MATCH_CLR;
    ticks(12);
    rd(SEL_COUNT, d);
    chk(d, 16'h0002);
  endtask
  // pwm high while count below duty four
  task automatic t_pwm;
    do_reset();
    wr(SEL_CC_ZERO, 16'h0010);
    ctrl.mode = MODE_PWM;
    ticks(3);
    chk({15'h0000, out_pin}, 16'h0001);
    ticks(1);
    @(negedge i_clk_sys);
    chk({15'h0000, out_pin}, 16'h0000);
  endtask
  // one-shot: set on one-match at 2, cleared on zero-match at 6
  task automatic t_oneshot;
    do_reset();
    wr(SEL_CC_ONE, 16'h0002);
    wr(SEL_CC_ZERO, 16'h0006);
    ctrl.one_shot = 1'h1;
    ctrl.mode = MODE_FREE;
    ticks(10);
    chk(high_cycles, 16'h0004);
  endtask

  // ====================
  // main sequence
  // ====================
  initial begin
    i_clk_sys = 1'h0;
    i_nrst = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_sel = '0;
    reg_wdata = '0;
    ctrl = '0;
    tick = 1'h0;
    ovf_clear = 1'h0;
    want_a = 1'h0;
    want_b = 1'h0;
    n_errors = 0;
    samples_checked = 0;
    n_flag = 0;
    t_reset();
    t_match();
    t_stop();
    t_cap_zero();
    t_cap_one();
    t_event();
    t_clear();
    t_pwm();
    t_oneshot();
    t_wrap();
    close_out();
  end
endmodule

`default_nettype wire
